// file: src/ecb_bus_if.sv
// Wired coordination bus joining the node and one peer.
`timescale 1ns/1ps
interface ecb_bus_if;
    // Node drive side
    logic node_trig_o, node_trig_oe;
    logic node_rdy_oe;
    logic node_exec_o, node_exec_oe;
    // Peer drive side
    logic peer_trig_o, peer_trig_oe;
    logic peer_rdy_oe;
    logic peer_exec_o, peer_exec_oe;
    // Resolved lines; low-true lines pulled high, ready pulled high
    logic trig_n_line;
    logic ready_line;
    logic exec_n_line;
    assign trig_n_line = !((node_trig_oe && !node_trig_o) || (peer_trig_oe && !peer_trig_o));
    assign exec_n_line = !((node_exec_oe && !node_exec_o) || (peer_exec_oe && !peer_exec_o));
    assign ready_line  = !(node_rdy_oe || peer_rdy_oe);
    modport node
    (
        output node_trig_o, node_trig_oe, node_rdy_oe, node_exec_o, node_exec_oe,
        input  trig_n_line, ready_line, exec_n_line
    );
    modport peer
    (
        output peer_trig_o, peer_trig_oe, peer_rdy_oe, peer_exec_o, peer_exec_oe,
        input  trig_n_line, ready_line, exec_n_line
    );
endinterface : ecb_bus_if

// file: src/ecb_defs.svh
// Shared constants for the emulator coordination bus node.
`ifndef ECB_DEFS_SVH
`define ECB_DEFS_SVH
`define ECB_SYNC_STAGES    2
`define ECB_ACT_WINDOW     16'h00ff
`define ECB_DEPTH_MAX      8'd0
`define ECB_ROUTE_OFF      2'h0
`define ECB_ROUTE_DRIVE    2'h1
`define ECB_ROUTE_RECEIVE  2'h2
`define ECB_SEL_LINE_A     1'h0
`define ECB_SEL_LINE_B     1'h1
`define ECB_ACT_LOW        2'h0
`define ECB_ACT_HIGH       2'h1
`define ECB_ACT_MOVING     2'h2
`endif

// file: src/ecb_node.sv
// Emulator node: bus handshake, trigger routing, activity and trace depth.
`timescale 1ns/1ps
`include "ecb_defs.svh"
module ecb_node
    import ecb_pkg::*;
#(
    parameter int ADDR_W  = 32,
    parameter int DEPTH_W = 8,
    parameter int ACT_N   = 4
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Bus side
    ecb_bus_if.node                 bus,
    // Configuration
    input  wire logic               bus_enable,
    input  wire logic               fg_monitor,
    input  wire logic [1:0]         route_bus_a,
    input  wire logic [1:0]         route_bus_b,
    input  wire logic [1:0]         route_conn_a,
    input  wire logic [1:0]         route_conn_b,
    input  wire logic [1:0]         route_ana_a,
    input  wire logic [1:0]         route_ana_b,
    input  wire logic               arm_sel,
    input  wire logic               break_en_conn,
    input  wire logic               break_en_bus,
    input  wire logic               break_en_ana,
    input  wire logic               trace_on_exec,
    input  wire logic [ADDR_W-1:0]  run_address,
    input  wire logic [DEPTH_W-1:0] trace_depth,
    // Emulator side
    input  wire logic               emu_prepared,
    input  wire logic               user_break,
    input  wire logic               user_exec,
    input  wire logic               conn_trig_in,
    input  wire logic               ana_trigger,
    input  wire logic               ana_store,
    input  wire logic               trace_start,
    input  wire logic [ACT_N-1:0]   ana_lines,
    output logic                    emu_running,
    output logic                    emu_monitor,
    output logic                    run_from_addr,
    output logic [ADDR_W-1:0]       run_addr_out,
    output logic                    conn_trig_out,
    output logic                    ana_armed,
    output logic                    ana_complete,
    output logic                    ana_tracing,
    output logic [2*ACT_N-1:0]      signal_activity_monitor
);
    if (ADDR_W < 1 || DEPTH_W < 1 || DEPTH_W > 16 || ACT_N < 1)
    begin : bad_params
        $error("ecb_node: unsupported parameters");
    end

    // =====================================================
    // Input synchronisers
    logic [2:0] s1_reg, s2_reg, s3_reg;
    logic [ACT_N-1:0] a1_reg, a2_reg;
    always_ff @(posedge clk)
    begin
        s1_reg <= {bus.trig_n_line, bus.ready_line, bus.exec_n_line};
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        a1_reg <= ana_lines;
        a2_reg <= a1_reg;
    end
    logic bus_trig, ready, exec_edge;
    assign bus_trig  = !s2_reg[2];
    assign ready     = s2_reg[1];
    assign exec_edge = s3_reg[0] && !s2_reg[0];

    // =====================================================
    // Internal trigger lines
    function automatic logic recv(input logic [1:0] r, input logic v);
        recv = (r == `ECB_ROUTE_DRIVE) && v;
    endfunction : recv
    logic line_a, line_b, line_a_d_reg, line_b_d_reg;
    assign line_a = recv(route_bus_a, bus_trig) || recv(route_conn_a, conn_trig_in)
                  || recv(route_ana_a, ana_trigger);
    assign line_b = recv(route_bus_b, bus_trig) || recv(route_conn_b, conn_trig_in)
                  || recv(route_ana_b, ana_trigger);
    logic bus_trig_next, conn_trig_next;
    always_comb
    begin
        bus_trig_next  = (route_bus_a == `ECB_ROUTE_RECEIVE && line_a)
                       || (route_bus_b == `ECB_ROUTE_RECEIVE && line_b);
        conn_trig_next = (route_conn_a == `ECB_ROUTE_RECEIVE && line_a)
                       || (route_conn_b == `ECB_ROUTE_RECEIVE && line_b);
    end

    // =====================================================
    // Run control
    ecb_state_type st_reg, st_next;
    logic exec_pend_reg, exec_pend_next, rfa_next, rdy_oe_next;
    logic brk_req;
    // Monitor kind does not change the handshake, so fg_monitor is left unused
    assign brk_req = user_break || (break_en_conn && conn_trig_in)
                   || (break_en_bus && bus_trig)
                   || (break_en_ana && ana_trigger)
                   || (bus_enable && !ready);
    always_comb
    begin
        st_next        = st_reg;
        exec_pend_next = exec_pend_reg || (bus_enable && exec_edge);
        rfa_next       = 1'b0;
        unique case (st_reg)
            ECB_RESET:   st_next = ECB_BREAK;
            ECB_RUN:     if (brk_req) st_next = ECB_BREAK;
            ECB_BREAK:   if (emu_prepared && !user_break) st_next = ECB_WAITRDY;
            ECB_WAITRDY:
            begin
                if (user_break)
                    st_next = ECB_BREAK;
                else if (!bus_enable || ready)
                begin
                    st_next        = ECB_RUN;
                    rfa_next       = exec_pend_reg;
                    exec_pend_next = 1'b0;
                end
            end
            default:     st_next = ECB_BREAK;
        endcase
        // Only a parked node holds ready low, reset included
        rdy_oe_next = bus_enable && (st_next == ECB_BREAK || st_next == ECB_RESET);
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_reg        <= ECB_RESET;
            exec_pend_reg <= 1'b0;
            run_from_addr <= 1'b0;
            run_addr_out  <= '0;
            bus.node_rdy_oe <= 1'b1;
        end
        else
        begin
            st_reg        <= st_next;
            exec_pend_reg <= exec_pend_next;
            run_from_addr <= rfa_next;
            run_addr_out  <= run_address;
            bus.node_rdy_oe <= rdy_oe_next;
        end
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            emu_running <= 1'b0;
            emu_monitor <= 1'b1;
        end
        else
        begin
            emu_running <= (st_next == ECB_RUN);
            emu_monitor <= (st_next != ECB_RUN);
        end
    end

    // =====================================================
    // Bus drive of trigger and execute
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bus.node_trig_o  <= 1'b1;
            bus.node_trig_oe <= 1'b0;
            bus.node_exec_o  <= 1'b1;
            bus.node_exec_oe <= 1'b0;
            conn_trig_out    <= 1'b0;
        end
        else
        begin
            bus.node_trig_o  <= !bus_trig_next;
            bus.node_trig_oe <= bus_trig_next;
            bus.node_exec_o  <= !(user_exec && bus_enable);
            bus.node_exec_oe <= user_exec && bus_enable;
            conn_trig_out    <= conn_trig_next;
        end
    end

    // =====================================================
    // Trace arm and depth completion
    ecb_trace_type tr_reg, tr_next;
    logic arm_next;
    logic [DEPTH_W-1:0] cnt_reg, cnt_next, depth_eff;
    logic sel_line, sel_d;
    // Depth zero is compared and mapped to all ones, so it selects a full memory of 2**DEPTH_W stores
    assign depth_eff = (trace_depth == DEPTH_W'(`ECB_DEPTH_MAX)) ? '1
                     : trace_depth - 1'b1;
    assign sel_line  = (arm_sel == `ECB_SEL_LINE_A) ? line_a : line_b;
    assign sel_d     = (arm_sel == `ECB_SEL_LINE_A) ? line_a_d_reg : line_b_d_reg;
    always_comb
    begin
        tr_next  = tr_reg;
        arm_next = ana_armed;
        cnt_next = cnt_reg;
        unique case (tr_reg)
            ECB_TR_IDLE, ECB_TR_DONE:
            begin
                tr_next = tr_reg;
            end
            ECB_TR_PRE:
            begin
                if (sel_line && !sel_d) arm_next = 1'b1;
                if (ana_trigger && ana_store)
                begin
                    tr_next = (depth_eff == '0) ? ECB_TR_DONE : ECB_TR_POST;
                    cnt_next = '0;
                end
            end
            ECB_TR_POST:
            begin
                if (sel_line && !sel_d) arm_next = 1'b1;
                if (ana_store)
                begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg + 1'b1 == depth_eff) tr_next = ECB_TR_DONE;
                end
            end
        endcase
        // A new start restarts a trace still in progress, so arm is relearned
        if (trace_start || (trace_on_exec && bus_enable && exec_edge))
        begin
            tr_next  = ECB_TR_PRE;
            arm_next = 1'b0;
            cnt_next = '0;
        end
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tr_reg       <= ECB_TR_IDLE;
            ana_armed    <= 1'b0;
            cnt_reg      <= '0;
            line_a_d_reg <= 1'b0;
            line_b_d_reg <= 1'b0;
            ana_complete <= 1'b0;
            ana_tracing  <= 1'b0;
        end
        else
        begin
            tr_reg       <= tr_next;
            ana_armed    <= arm_next;
            cnt_reg      <= cnt_next;
            line_a_d_reg <= line_a;
            line_b_d_reg <= line_b;
            ana_complete <= (tr_next == ECB_TR_DONE);
            ana_tracing  <= (tr_next == ECB_TR_PRE) || (tr_next == ECB_TR_POST);
        end
    end

    // =====================================================
    // Signal activity monitor over a fixed window
    logic [15:0] win_reg;
    logic [ACT_N-1:0] seen_hi_reg, seen_lo_reg;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            win_reg     <= '0;
            seen_hi_reg <= '0;
            seen_lo_reg <= '0;
            signal_activity_monitor <= '0;
        end
        else if (win_reg == `ECB_ACT_WINDOW)
        begin
            win_reg     <= '0;
            seen_hi_reg <= a2_reg;
            seen_lo_reg <= ~a2_reg;
            for (int i = 0; i < ACT_N; i++)
                signal_activity_monitor[2*i +: 2] <=
                    (seen_hi_reg[i] && seen_lo_reg[i]) ? `ECB_ACT_MOVING :
                    seen_hi_reg[i] ? `ECB_ACT_HIGH : `ECB_ACT_LOW;
        end
        else
        begin
            win_reg     <= win_reg + 16'h0001;
            seen_hi_reg <= seen_hi_reg | a2_reg;
            seen_lo_reg <= seen_lo_reg | ~a2_reg;
        end
    end
endmodule : ecb_node

// file: src/ecb_peer.sv
// Peer node: drives and samples the shared coordination lines.
`timescale 1ns/1ps
`include "ecb_defs.svh"
module ecb_peer
    import ecb_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Bus side
    ecb_bus_if.peer   bus,
    // User side
    input  wire logic peer_enable,
    input  wire logic peer_prepared,
    input  wire logic peer_trig_req,
    input  wire logic peer_exec_req,
    output logic      peer_trig_seen,
    output logic      peer_exec_seen,
    output logic      peer_ready_seen
);
    // =====================================================
    // Synchronise the wired lines
    logic [2:0] s1_reg, s2_reg, s3_reg;
    always_ff @(posedge clk)
    begin
        s1_reg <= {bus.trig_n_line, bus.ready_line, bus.exec_n_line};
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // =====================================================
    // Drive and observe
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bus.peer_trig_o  <= 1'b1;
            bus.peer_trig_oe <= 1'b0;
            bus.peer_exec_o  <= 1'b1;
            bus.peer_exec_oe <= 1'b0;
            bus.peer_rdy_oe  <= 1'b1;
            peer_trig_seen   <= 1'b0;
            peer_exec_seen   <= 1'b0;
            peer_ready_seen  <= 1'b0;
        end
        else
        begin
            bus.peer_trig_o  <= !peer_trig_req;
            bus.peer_trig_oe <= peer_trig_req;
            bus.peer_exec_o  <= !peer_exec_req;
            bus.peer_exec_oe <= peer_exec_req;
            bus.peer_rdy_oe  <= peer_enable && !peer_prepared;
            peer_trig_seen   <= !s2_reg[2];
            peer_exec_seen   <= s3_reg[0] && !s2_reg[0];
            peer_ready_seen  <= s2_reg[1];
        end
    end
endmodule : ecb_peer

// file: src/ecb_pkg.sv
// Types shared by both ends of the coordination bus.
package ecb_pkg;
    typedef enum logic [2:0]
    {
        ECB_RUN     = 3'b000,
        ECB_BREAK   = 3'b001,
        ECB_WAITRDY = 3'b010,
        ECB_RESET   = 3'b011
    } ecb_state_type;
    typedef enum logic [1:0]
    {
        ECB_TR_IDLE = 2'b00,
        ECB_TR_PRE  = 2'b01,
        ECB_TR_POST = 2'b10,
        ECB_TR_DONE = 2'b11
    } ecb_trace_type;
endpackage : ecb_pkg

// file: verif/ecb_node_checker.sv
// Concurrent checks on the coordination bus wires of the node.
`timescale 1ns/1ps
module ecb_node_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Node drive side
    input wire logic node_trig_o,
    input wire logic node_trig_oe,
    input wire logic node_rdy_oe,
    input wire logic node_exec_o,
    input wire logic node_exec_oe,
    // Resolved lines
    input wire logic trig_n_line,
    input wire logic ready_line,
    input wire logic exec_n_line
);
    // =====================================
    // Helper
    // Only an enabled node pulls ready in the first cycle after reset,
    // so that cycle tells whether the break-on-ready check applies at all
    logic live_reg;
    logic live_next;
    logic engaged_reg;
    logic engaged_next;
    always_comb
    begin
        live_next    = resetn;
        engaged_next = resetn && (engaged_reg || (live_reg && node_rdy_oe));
    end
    always_ff @(posedge clk)
    begin
        live_reg    <= live_next;
        engaged_reg <= engaged_next;
    end
    // =====================================
    // Assertions
    AST_RESET_PULLS_READY : assert property
        (@(posedge clk) !resetn |=> node_rdy_oe && !ready_line)
        else $error("ready not held low during reset");
    AST_RESET_NO_DRIVE : assert property
        (@(posedge clk) !resetn |=> !node_trig_oe && !node_exec_oe)
        else $error("trigger or execute driven during reset");
    AST_BREAK_ON_READY : assert property
        (@(posedge clk) disable iff (!resetn)
        engaged_reg && $fell(ready_line) && !node_rdy_oe |-> ##[2:6] node_rdy_oe)
        else $error("node did not pull ready after ready fell");
    AST_READY_SYNCED : assert property
        (@(posedge clk) disable iff (!resetn)
        $fell(ready_line) && !node_rdy_oe |-> !node_rdy_oe [*3])
        else $error("node reacted to ready before two sync stages");
    AST_READY_WIRED_AND : assert property
        (@(posedge clk) disable iff (!resetn) node_rdy_oe |-> !ready_line)
        else $error("ready high while node pulls it");
    AST_TRIG_WIRED : assert property
        (@(posedge clk) disable iff (!resetn) node_trig_oe && !node_trig_o |-> !trig_n_line)
        else $error("trigger line not low while node drives it");
    AST_EXEC_WIRED : assert property
        (@(posedge clk) disable iff (!resetn) node_exec_oe && !node_exec_o |-> !exec_n_line)
        else $error("execute line not low while node drives it");
    AST_RESET_LINES_IDLE : assert property
        (@(posedge clk) !resetn ##1 !resetn |-> trig_n_line && exec_n_line)
        else $error("low-true lines not idle during reset");
endmodule : ecb_node_checker

// file: verif/emulator_coordination_bus_node_test.sv
// Self-checking bench: node and peer joined across the coordination bus.
`timescale 1ns/1ps
`include "ecb_defs.svh"
module emulator_coordination_bus_node_test;
    logic        clk, resetn, bus_enable, fg_monitor, arm_sel, trace_on_exec;
    logic [1:0]  route_bus_a, route_bus_b, route_conn_a, route_conn_b, route_ana_a, route_ana_b;
    logic        break_en_conn, break_en_bus, break_en_ana, emu_prepared, user_break, user_exec;
    logic        conn_trig_in, ana_trigger, ana_store, trace_start, emu_running, emu_monitor;
    logic        run_from_addr, conn_trig_out, ana_armed, ana_complete, ana_tracing;
    logic        peer_enable, peer_prepared, peer_trig_req, peer_exec_req;
    logic        peer_trig_seen, peer_exec_seen, peer_ready_seen, seen_rfa, seen_px, seen_pt;
    logic        seen_clr;
    logic [31:0] run_address, run_addr_out, seen_addr;
    logic [3:0]  trace_depth, ana_lines;
    logic [7:0]  signal_activity_monitor;
    int          num_errors = 0;
    int          samples_checked = 0;
    // =====================================
    // Structure
    ecb_bus_if bif ();
    ecb_node #(.DEPTH_W(4)) ecb_node_inst (.clk, .resetn, .bus(bif), .bus_enable, .fg_monitor,
        .route_bus_a, .route_bus_b, .route_conn_a, .route_conn_b, .route_ana_a, .route_ana_b,
        .arm_sel, .break_en_conn, .break_en_bus, .break_en_ana, .trace_on_exec, .run_address,
        .trace_depth, .emu_prepared, .user_break, .user_exec, .conn_trig_in, .ana_trigger,
        .ana_store, .trace_start, .ana_lines, .emu_running, .emu_monitor, .run_from_addr,
        .run_addr_out, .conn_trig_out, .ana_armed, .ana_complete, .ana_tracing,
        .signal_activity_monitor);
    ecb_peer ecb_peer_inst (.clk, .resetn, .bus(bif), .peer_enable, .peer_prepared,
        .peer_trig_req, .peer_exec_req, .peer_trig_seen, .peer_exec_seen, .peer_ready_seen);
    ecb_node_checker ecb_node_checker_inst (.clk, .resetn, .node_trig_o(bif.node_trig_o),
        .node_trig_oe(bif.node_trig_oe), .node_rdy_oe(bif.node_rdy_oe),
        .node_exec_o(bif.node_exec_o), .node_exec_oe(bif.node_exec_oe),
        .trig_n_line(bif.trig_n_line), .ready_line(bif.ready_line),
        .exec_n_line(bif.exec_n_line));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Pulses are caught here so a one-cycle output is never missed
    always @(posedge clk)
    begin
        if (run_from_addr === 1'b1)
            seen_addr <= run_addr_out;
        seen_rfa <= !seen_clr && (seen_rfa | (run_from_addr === 1'b1));
        seen_px  <= !seen_clr && (seen_px | (peer_exec_seen === 1'b1));
        seen_pt  <= !seen_clr && (seen_pt | (peer_trig_seen === 1'b1));
    end
    // =====================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic clear_seen();
        seen_clr = 1'b1;
        cyc(1);
        seen_clr = 1'b0;
    endtask : clear_seen
    task automatic wait_run(input logic v);
        for (int i = 0; i < 30 && emu_running !== v; i++)
            @(negedge clk);
    endtask : wait_run
    task automatic do_reset(input logic en);
        bus_enable = en;
        resetn = 1'b0;
        seen_clr = 1'b1;
        cyc(3);
        check("rdy_oe in reset", bif.node_rdy_oe, 1'b1);
        cyc(9);
        resetn = 1'b1;
        seen_clr = 1'b0;
    endtask : do_reset
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // =====================================
    // Scenarios
    task automatic t_start();
        peer_prepared = 1'b0;
        do_reset(1'b1);
        cyc(10);
        check("run before ready", emu_running, 1'b0);
        check("ready low", bif.ready_line, 1'b0);
        check("peer ready low", peer_ready_seen, 1'b0);
        peer_prepared = 1'b1;
        wait_run(1'b1);
        check("run after ready", emu_running, 1'b1);
        check("ready high", bif.ready_line, 1'b1);
        check("peer ready high", peer_ready_seen, 1'b1);
        $display("test start done");
    endtask : t_start
    task automatic t_break();
        fg_monitor = 1'b1;
        emu_prepared = 1'b0;
        peer_prepared = 1'b0;
        wait_run(1'b0);
        check("break on ready", emu_running, 1'b0);
        check("monitor", emu_monitor, 1'b1);
        peer_prepared = 1'b1;
        cyc(10);
        check("hold ready", bif.node_rdy_oe, 1'b1);
        check("parked", emu_running, 1'b0);
        emu_prepared = 1'b1;
        wait_run(1'b1);
        check("resume", emu_running, 1'b1);
        fg_monitor = 1'b0;
        $display("test break done");
    endtask : t_break
    task automatic t_exec();
        trace_on_exec = 1'b1;
        run_address = 32'h00004a10;
        emu_prepared = 1'b0;
        user_break = 1'b1;
        wait_run(1'b0);
        user_break = 1'b0;
        peer_exec_req = 1'b1;
        cyc(2);
        peer_exec_req = 1'b0;
        cyc(6);
        check("trace on exec", ana_tracing, 1'b1);
        check("wait for ready", emu_running, 1'b0);
        clear_seen();
        emu_prepared = 1'b1;
        cyc(30);
        check("run from address", seen_rfa, 1'b1);
        check("run address", seen_addr, run_address);
        trace_on_exec = 1'b0;
        clear_seen();
        user_exec = 1'b1;
        cyc(10);
        user_exec = 1'b0;
        check("peer saw exec", seen_px, 1'b1);
        $display("test exec done");
    endtask : t_exec
    task automatic t_trig();
        route_bus_a = 2'h1;
        route_conn_a = 2'h2;
        peer_trig_req = 1'b1;
        for (int i = 0; i < 20 && conn_trig_out !== 1'b1; i++)
            @(negedge clk);
        check("bus to connector", conn_trig_out, 1'b1);
        {peer_trig_req, route_bus_a, route_conn_a, route_ana_b, route_bus_b} = 9'h006;
        // Let the peer's own trigger drain before watching for ours
        cyc(6);
        clear_seen();
        ana_trigger = 1'b1;
        cyc(10);
        ana_trigger = 1'b0;
        check("peer saw trigger", seen_pt, 1'b1);
        {route_ana_b, route_bus_b} = 4'h0;
        {conn_trig_in, peer_trig_req, ana_trigger} = 3'h7;
        cyc(10);
        check("masked sources", emu_running, 1'b1);
        {conn_trig_in, peer_trig_req, ana_trigger} = 3'h0;
        cyc(4);
        for (int k = 0; k < 3; k++)
        begin
            {break_en_conn, break_en_bus, break_en_ana} = 3'h4 >> k;
            {conn_trig_in, peer_trig_req, ana_trigger} = 3'h4 >> k;
            wait_run(1'b0);
            check("break source", emu_running, 1'b0);
            {conn_trig_in, peer_trig_req, ana_trigger} = 3'h0;
            wait_run(1'b1);
            check("rerun", emu_running, 1'b1);
        end
        {break_en_conn, break_en_bus, break_en_ana} = 3'h0;
        $display("test trigger done");
    endtask : t_trig
    task automatic t_arm();
        for (int s = 0; s < 2; s++)
        begin
            arm_sel = s[0];
            route_conn_a = s[0] ? 2'h0 : 2'h1;
            route_conn_b = s[0] ? 2'h1 : 2'h0;
            conn_trig_in = 1'b1;
            cyc(4);
            trace_start = 1'b1;
            cyc(1);
            trace_start = 1'b0;
            cyc(6);
            check("no arm on level", ana_armed, 1'b0);
            conn_trig_in = 1'b0;
            cyc(4);
            conn_trig_in = 1'b1;
            cyc(6);
            check("armed", ana_armed, 1'b1);
            conn_trig_in = 1'b0;
            cyc(6);
            check("arm stays", ana_armed, 1'b1);
        end
        {route_conn_a, route_conn_b} = 4'h0;
        $display("test arm done");
    endtask : t_arm
    task automatic t_depth(input logic [3:0] depth, input int n);
        trace_depth = depth;
        trace_start = 1'b1;
        cyc(1);
        trace_start = 1'b0;
        ana_store = 1'b1;
        cyc(2);
        ana_store = 1'b0;
        cyc(4);
        check("no trigger yet", ana_complete, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            {ana_store, ana_trigger} = {1'b1, 1'(i == 0)};
            cyc(1);
            {ana_store, ana_trigger} = 2'h0;
            cyc(3);
            if (i == n - 2)
                check("one state short", ana_complete, 1'b0);
        end
        check("complete", ana_complete, 1'b1);
        $display("test depth done");
    endtask : t_depth
    task automatic t_act();
        ana_lines = 4'ha;
        repeat (600)
        begin
            @(negedge clk);
            ana_lines[2] = ~ana_lines[2];
        end
        check("activity", signal_activity_monitor,
            {`ECB_ACT_HIGH, `ECB_ACT_MOVING, `ECB_ACT_HIGH, `ECB_ACT_LOW});
        ana_lines = 4'he;
        cyc(600);
        check("activity settled", signal_activity_monitor,
            {`ECB_ACT_HIGH, `ECB_ACT_HIGH, `ECB_ACT_HIGH, `ECB_ACT_LOW});
        $display("test activity done");
    endtask : t_act
    task automatic t_refuse();
        peer_prepared = 1'b0;
        do_reset(1'b0);
        wait_run(1'b1);
        cyc(4);
        check("no ready drive", bif.node_rdy_oe, 1'b0);
        clear_seen();
        {user_break, peer_exec_req} = 2'h3;
        cyc(4);
        {user_break, peer_exec_req} = 2'h0;
        cyc(20);
        check("exec ignored", seen_rfa, 1'b0);
        check("runs without ready", emu_running, 1'b1);
        $display("test disabled done");
    endtask : t_refuse
    // =====================================
    // Main sequence and watchdog
    initial
    begin
        {resetn, bus_enable, fg_monitor, arm_sel, trace_on_exec, user_break, user_exec} = 7'h0;
        {route_bus_a, route_bus_b, route_conn_a, route_conn_b, route_ana_a, route_ana_b} = 12'h0;
        {break_en_conn, break_en_bus, break_en_ana, conn_trig_in, ana_trigger} = 5'h0;
        {ana_store, trace_start, peer_trig_req, peer_exec_req} = 4'h0;
        {emu_prepared, peer_enable, peer_prepared} = 3'h7;
        {run_address, trace_depth, ana_lines} = 40'h0;
        t_start();
        t_break();
        t_exec();
        t_trig();
        t_arm();
        t_depth(4'h3, 3);
        t_depth(4'h1, 1);
        t_depth(4'h0, 16);
        t_act();
        t_refuse();
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : emulator_coordination_bus_node_test
